// [core/slio_pkg.sv]
// package for the supply logic i/o and fault pin block
// assumes a 40 MHz system clock and an apb register port
package slio_pkg;
	// ==========================================================
	// register byte offsets
	// flag select words are kept by word index; the byte address is four times the index
	localparam logic [7:0] SLIO_FLAG_SEL_LO_IDX = 8'h1a;
	localparam logic [7:0] SLIO_FLAG_SEL_HI_IDX = 8'h1b;
	localparam logic [7:0] SLIO_FLAG_SEL_LO_OFF = SLIO_FLAG_SEL_LO_IDX * 8'h04; // crowbar flag select, low
	localparam logic [7:0] SLIO_FLAG_SEL_HI_OFF = SLIO_FLAG_SEL_HI_IDX * 8'h04; // crowbar flag select, high
	localparam logic [7:0] SLIO_PIN_CFG_OFF     = 8'h00; // pin function and polarity
	localparam logic [7:0] SLIO_THR_CFG_OFF     = 8'h04; // comparator thresholds
	localparam logic [7:0] SLIO_CTRL_OFF        = 8'h08; // processor written control
	localparam logic [7:0] SLIO_STATUS_OFF      = 8'h0c; // comparator and output status
	localparam logic [7:0] SLIO_MON_CFG_OFF     = 8'h10; // monitor protect mode and sense
	// ==========================================================
	// pin configuration field positions
	localparam int SLIO_CFG_GATE_INV   = 0;
	localparam int SLIO_CFG_CB_LATCH   = 1;
	localparam int SLIO_CFG_CB_PCH     = 2;
	localparam int SLIO_CFG_CB_INV     = 3;
	localparam int SLIO_CFG_CB_ALERT   = 4;
	localparam int SLIO_CFG_MONITOR_INPUT_1_SEL   = 5;
	localparam int SLIO_CFG_MONITOR_INPUT_2_SEL   = 6;
	localparam int SLIO_CFG_PEN_LOW    = 7;
	localparam int SLIO_CFG_SON_LOW    = 8;
	localparam int SLIO_CFG_MONITOR_INPUT_3_SEL   = 9;
	localparam int SLIO_CFG_MONITOR_INPUT_4_SEL   = 10;
	localparam int SLIO_CFG_AC_SRC2    = 11;
	localparam int SLIO_CFG_AC_PCH     = 12;
	localparam int SLIO_CFG_AC_INV     = 13;
	localparam int SLIO_CFG_REF_LO     = 14; // 2-bit field, see ref modes
	localparam int SLIO_CFG_OTP_LATCH  = 16;
	localparam int SLIO_CFG_LINK_MODE  = 17;
	localparam int SLIO_CFG_SON_BREAK  = 18;
	localparam int SLIO_CFG_LOCK       = 19;
	localparam int SLIO_CFG_W          = 20;
	// reference pin modes
	localparam logic [1:0] SLIO_REF_OUT  = 2'h0;
	localparam logic [1:0] SLIO_REF_ACOK = 2'h1;
	localparam logic [1:0] SLIO_REF_MONITOR_INPUT_5 = 2'h2;
	// fault flag bit positions, fourteen flags
	localparam int SLIO_FLAG_W = 14;
	// reset values
	localparam logic [SLIO_CFG_W-1:0] SLIO_CFG_RST = 20'h00000;
	localparam logic [3:0] SLIO_ON_THR_RST  = 4'h0; // 20 mV code
	localparam logic [3:0] SLIO_OFF_THR_RST = 4'h0; // 100 mV code
	// ==========================================================
	// timing: delay counters are three bits, one tick per prescaled period
	localparam int SLIO_CLK_MHZ     = 40;
	localparam int SLIO_TICK_NS     = 200;
	localparam int SLIO_TICK_CYC    = (SLIO_TICK_NS * SLIO_CLK_MHZ) / 1000;
	localparam logic [2:0] SLIO_ON_DLY_TICKS = 3'h4;
	localparam logic [2:0] SLIO_RESTART_TICKS = 3'h7;
endpackage

// [core/slio_core.sv]
// logic i/o, oring gate control and fault pins of the supply manager
// assumes synchronous comparator results and an apb master on the system clock
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Operation
// - gate on only when voltage near zero
// - reverse voltage past threshold turns gate off
// - inverted gate: off falls, on rises
// - delays from small three bit counters
// - unused pins become monitor comparators
// - comparator status readable, control bits writable
// - crowbar on selected flags, 1ah and 1bh
// - crowbar latching or following
// - crowbar n or p drain, true or inverted
// - crowbar pin alternatively alert output
// - monitor one selected forces sense one true
// - monitor two selected forces sense two true
// - converter enable with selectable level
// - supply on from pin or bus, gated by link
// - monitor three selected clears supply on
// - output good only while outputs in tolerance
// - line good follows chosen sense source
// - line good n or p drain, polarity
// - overtemperature latches off or auto restarts
// - reference pin: reference, line good, monitor
// - slave only; link lines when unused
// - default gate rests high until start conditions
module slio_core (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        near_zero_cmp,
	input  wire logic        reverse_cmp,
	input  wire logic        line_sense_1,
	input  wire logic        line_sense_2,
	input  wire logic        supply_on_request,
	input  wire logic        dc_in_tolerance,
	input  wire logic        ov_fault,
	input  wire logic        uv_fault,
	input  wire logic        oc_fault,
	input  wire logic        monitor_input_1,
	input  wire logic        monitor_input_2,
	input  wire logic        monitor_input_3,
	input  wire logic        monitor_input_4,
	input  wire logic        monitor_input_5,
	input  wire logic        supply_on_share_line_in,
	output logic             supply_on_share_line_out,
	output logic             supply_on_share_line_oe,
	input  wire logic        line_good_share_line_in,
	output logic             line_good_share_line_out,
	output logic             line_good_share_line_oe,
	output logic             gate_drive_out,
	output logic             gate_drive_oe,
	output logic             crowbar_drive_out,
	output logic             crowbar_drive_oe,
	output logic             converter_enable_out,
	output logic             output_power_good,
	output logic             output_power_good_oe,
	output logic             line_power_good,
	output logic             line_power_good_oe,
	output logic             ref_enable_out,
	output logic [3:0]       on_thr_code,
	output logic [3:0]       off_thr_code
);
	import slio_pkg::*;

	typedef struct packed {
		logic [SLIO_CFG_W-1:0]  cfg;
		logic [3:0]             on_thr;
		logic [3:0]             off_thr;
		logic [SLIO_FLAG_W-1:0] flag_sel;
		logic [4:0]             mon_ovp;    // 1 = overvoltage, 0 = undervoltage
		logic [4:0]             mon_pos;    // 1 = positive going sense
		logic                   sw_fault;
		logic                   sw_son;
		logic                   sw_line_ok;
		logic                   cb_latched;
		logic                   otp_latched;
		logic                   gate_on;
		logic                   power_on;
		logic [7:0]             prescale;
		logic [2:0]             dly_cnt;
		logic [2:0]             rst_cnt;
		logic                   gate_q;
		logic                   gate_oe_q;
		logic                   cb_q;
		logic                   cb_oe_q;
		logic                   pen_q;
		logic                   dcg_q;
		logic                   dcg_oe_q;
		logic                   acg_q;
		logic                   acg_oe_q;
		logic                   son_link_q;
		logic                   acg_link_q;
		logic [31:0]            rdata;
	} slio_state_t;

	slio_state_t st_reg;
	slio_state_t st_next;

	// open drain pin: n channel pulls low while inactive, p channel drives high while active
	function automatic logic [1:0] od_pin(input logic act, input logic pch, input logic inv);
		logic lvl;
		lvl = act ^ inv;
		od_pin = pch ? {1'b1, lvl} : {1'b0, ~lvl};
	endfunction

	// monitor comparator qualified by sense direction; protect type is applied in the flag vector
	function automatic logic mon_fault(input logic raw, input logic pos);
		mon_fault = pos ? raw : ~raw;
	endfunction

	logic                   acc;
	logic                   tick;
	logic                   sense1;
	logic                   sense2;
	logic                   son_req;
	logic                   line_ok;
	logic [4:0]             mon_flt;
	logic                   otp_now;
	logic [SLIO_FLAG_W-1:0] flags;
	logic                   cb_act;
	logic [1:0]             pin2;

	// ==========================================================
	// next state
	always_comb begin
		st_next = st_reg;
		acc     = psel && penable;
		tick    = (st_reg.prescale == 8'(SLIO_TICK_CYC - 1));
		st_next.prescale = tick ? 8'h00 : st_reg.prescale + 8'h01;

		// monitors with their own sense direction
		mon_flt[0] = mon_fault(monitor_input_1, st_reg.mon_pos[0]) & st_reg.cfg[SLIO_CFG_MONITOR_INPUT_1_SEL];
		mon_flt[1] = mon_fault(monitor_input_2, st_reg.mon_pos[1]) & st_reg.cfg[SLIO_CFG_MONITOR_INPUT_2_SEL];
		mon_flt[2] = mon_fault(monitor_input_3, st_reg.mon_pos[2]) & st_reg.cfg[SLIO_CFG_MONITOR_INPUT_3_SEL];
		mon_flt[3] = mon_fault(monitor_input_4, st_reg.mon_pos[3]) & st_reg.cfg[SLIO_CFG_MONITOR_INPUT_4_SEL];
		mon_flt[4] = mon_fault(monitor_input_5, st_reg.mon_pos[4])
		             & (st_reg.cfg[SLIO_CFG_REF_LO +: 2] == SLIO_REF_MONITOR_INPUT_5);
		otp_now = mon_flt[4];

		// forced line sense results when pins serve as monitors
		sense1 = st_reg.cfg[SLIO_CFG_MONITOR_INPUT_1_SEL] ? 1'b1 : line_sense_1;
		sense2 = st_reg.cfg[SLIO_CFG_MONITOR_INPUT_2_SEL] ? 1'b1 : line_sense_2;
		line_ok = st_reg.cfg[SLIO_CFG_AC_SRC2] ? sense2 : sense1;
		if (st_reg.cfg[SLIO_CFG_LINK_MODE]) begin
			line_ok = line_ok & line_good_share_line_in;
		end

		// supply on: pin, or bus write when path broken, gated by share line
		if (st_reg.cfg[SLIO_CFG_MONITOR_INPUT_3_SEL]) begin
			son_req = 1'b0;
		end else if (st_reg.cfg[SLIO_CFG_SON_BREAK]) begin
			son_req = st_reg.sw_son;
		end else begin
			son_req = supply_on_request ^ st_reg.cfg[SLIO_CFG_SON_LOW];
		end
		if (st_reg.cfg[SLIO_CFG_LINK_MODE]) begin
			son_req = son_req & supply_on_share_line_in;
		end

		// fault flag vector, selectable into the crowbar
		flags = {1'b0, st_reg.sw_fault, mon_flt[3:0] & st_reg.mon_ovp[3:0], mon_flt[3:0] & ~st_reg.mon_ovp[3:0],
		         st_reg.otp_latched | otp_now, oc_fault, uv_fault, ov_fault};
		cb_act = |(flags & st_reg.flag_sel);
		if (st_reg.cfg[SLIO_CFG_CB_LATCH]) begin
			st_next.cb_latched = st_reg.cb_latched | cb_act;
		end else begin
			st_next.cb_latched = 1'b0;
		end

		// overtemperature latch or auto restart
		if (otp_now && st_reg.cfg[SLIO_CFG_OTP_LATCH]) begin
			st_next.otp_latched = 1'b1;
		end
		st_next.power_on = son_req && !st_reg.otp_latched && !otp_now && !st_reg.cb_latched && !cb_act;
		if (otp_now) begin
			st_next.rst_cnt = 3'h0;
		end else if (tick && st_reg.rst_cnt != SLIO_RESTART_TICKS) begin
			st_next.rst_cnt = st_reg.rst_cnt + 3'h1;
		end
		if (st_reg.rst_cnt != SLIO_RESTART_TICKS && !st_reg.cfg[SLIO_CFG_OTP_LATCH]) begin
			st_next.power_on = 1'b0;
		end

		// oring gate: reverse voltage wins at once, turn on after settle delay
		if (!st_reg.power_on || reverse_cmp) begin
			st_next.gate_on = 1'b0;
			st_next.dly_cnt = 3'h0;
		end else if (!st_reg.gate_on) begin
			if (!near_zero_cmp) begin
				st_next.dly_cnt = 3'h0;
			end else if (tick && st_reg.dly_cnt != SLIO_ON_DLY_TICKS) begin
				st_next.dly_cnt = st_reg.dly_cnt + 3'h1;
			end
			if (st_reg.dly_cnt == SLIO_ON_DLY_TICKS && near_zero_cmp) begin
				st_next.gate_on = 1'b1;
			end
		end

		// pin drivers, all registered
		st_next.gate_q    = st_reg.gate_on ^ ~st_reg.cfg[SLIO_CFG_GATE_INV];
		st_next.gate_oe_q = ~st_next.gate_q;
		pin2 = od_pin(st_reg.cb_latched | cb_act, st_reg.cfg[SLIO_CFG_CB_PCH], st_reg.cfg[SLIO_CFG_CB_INV]);
		if (st_reg.cfg[SLIO_CFG_CB_ALERT]) begin
			pin2 = {1'b0, st_reg.cb_latched | cb_act};
		end
		st_next.cb_q    = pin2[1];
		st_next.cb_oe_q = pin2[0];
		st_next.pen_q   = st_reg.power_on ^ st_reg.cfg[SLIO_CFG_PEN_LOW];
		pin2 = od_pin(st_reg.power_on & dc_in_tolerance, 1'b0, 1'b0);
		st_next.dcg_q    = pin2[1];
		st_next.dcg_oe_q = pin2[0] & ~st_reg.cfg[SLIO_CFG_MONITOR_INPUT_4_SEL];
		pin2 = od_pin(line_ok | st_reg.sw_line_ok, st_reg.cfg[SLIO_CFG_AC_PCH], st_reg.cfg[SLIO_CFG_AC_INV]);
		st_next.acg_q    = pin2[1];
		st_next.acg_oe_q = pin2[0] & (st_reg.cfg[SLIO_CFG_REF_LO +: 2] == SLIO_REF_ACOK);
		st_next.son_link_q = st_reg.cfg[SLIO_CFG_LINK_MODE] & ~st_reg.power_on;
		st_next.acg_link_q = st_reg.cfg[SLIO_CFG_LINK_MODE] & ~line_ok;

		// apb writes; pin selections lock once set
		if (acc && pwrite) begin
			unique case (paddr)
				SLIO_PIN_CFG_OFF: if (!st_reg.cfg[SLIO_CFG_LOCK]) begin
					st_next.cfg = pwdata[SLIO_CFG_W-1:0];
				end
				SLIO_THR_CFG_OFF: begin
					st_next.on_thr  = pwdata[3:0];
					st_next.off_thr = pwdata[7:4];
				end
				SLIO_CTRL_OFF: begin
					st_next.sw_fault   = pwdata[0];
					st_next.sw_son     = pwdata[1];
					st_next.sw_line_ok = pwdata[2];
					if (pwdata[3]) begin
						st_next.cb_latched  = cb_act;                  // set wins over clear
						st_next.otp_latched = otp_now & st_reg.cfg[SLIO_CFG_OTP_LATCH];
					end
				end
				SLIO_FLAG_SEL_LO_OFF: st_next.flag_sel[7:0] = pwdata[7:0];
				SLIO_FLAG_SEL_HI_OFF: st_next.flag_sel[SLIO_FLAG_W-1:8] = pwdata[SLIO_FLAG_W-9:0];
				SLIO_MON_CFG_OFF: if (!st_reg.cfg[SLIO_CFG_LOCK]) begin
					st_next.mon_ovp = pwdata[4:0];
					st_next.mon_pos = pwdata[12:8];
				end
				default: ;
			endcase
		end

		// apb read data, captured in setup so it stands at the access edge
		st_next.rdata = 32'h00000000;
		unique case (paddr)
			SLIO_PIN_CFG_OFF:     st_next.rdata = 32'(st_reg.cfg);
			SLIO_THR_CFG_OFF:     st_next.rdata = {24'h000000, st_reg.off_thr, st_reg.on_thr};
			SLIO_CTRL_OFF:        st_next.rdata = {29'h00000000, st_reg.sw_line_ok, st_reg.sw_son, st_reg.sw_fault};
			SLIO_STATUS_OFF:      st_next.rdata = {9'h000, flags, mon_flt, line_ok, son_req,
			                                       st_reg.power_on, st_reg.gate_on};
			SLIO_FLAG_SEL_LO_OFF: st_next.rdata = {24'h000000, st_reg.flag_sel[7:0]};
			SLIO_FLAG_SEL_HI_OFF: st_next.rdata = {26'h0000000, st_reg.flag_sel[SLIO_FLAG_W-1:8]};
			SLIO_MON_CFG_OFF:     st_next.rdata = {19'h00000, st_reg.mon_pos, 3'h0, st_reg.mon_ovp};
			default:              st_next.rdata = 32'h00000000;
		endcase
	end

	// ==========================================================
	// state register; gate rests off after reset
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg         <= '0;
			st_reg.cfg     <= SLIO_CFG_RST;
			st_reg.on_thr  <= SLIO_ON_THR_RST;
			st_reg.off_thr <= SLIO_OFF_THR_RST;
			st_reg.gate_q  <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// outputs; slave answers in the first access cycle, zero wait
	assign pready                   = 1'b1;
	assign pslverr                  = 1'b0;
	assign prdata                   = st_reg.rdata;
	assign gate_drive_out           = st_reg.gate_q;
	assign gate_drive_oe            = st_reg.gate_oe_q;
	assign crowbar_drive_out        = st_reg.cb_q;
	assign crowbar_drive_oe         = st_reg.cb_oe_q;
	assign converter_enable_out     = st_reg.pen_q;
	assign output_power_good        = st_reg.dcg_q;
	assign output_power_good_oe     = st_reg.dcg_oe_q;
	assign line_power_good          = st_reg.acg_q;
	assign line_power_good_oe       = st_reg.acg_oe_q;
	assign supply_on_share_line_out = 1'b0;
	assign supply_on_share_line_oe  = st_reg.son_link_q;
	assign line_good_share_line_out = 1'b0;
	assign line_good_share_line_oe  = st_reg.acg_link_q;
	assign ref_enable_out           = (st_reg.cfg[SLIO_CFG_REF_LO +: 2] == SLIO_REF_OUT);
	assign on_thr_code              = st_reg.on_thr;
	assign off_thr_code             = st_reg.off_thr;

	// ==========================================================
	// checks
	a_reverse_gate_off: assert property (@(posedge clock) disable iff (sys_rst)
		reverse_cmp |=> !st_reg.gate_on) else $error("gate stayed on under reverse voltage");
	a_gate_needs_zero: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(st_reg.gate_on) |-> $past(near_zero_cmp)) else $error("gate turned on without near zero");
	a_gate_polarity: assert property (@(posedge clock) disable iff (sys_rst)
		##1 gate_drive_out == ($past(st_reg.gate_on) ^ ~$past(st_reg.cfg[SLIO_CFG_GATE_INV])))
		else $error("gate pin polarity wrong");
	a_cb_latch_hold: assert property (@(posedge clock) disable iff (sys_rst)
		st_reg.cb_latched && st_reg.cfg[SLIO_CFG_CB_LATCH] && !(acc && pwrite && paddr == SLIO_CTRL_OFF)
		|=> st_reg.cb_latched) else $error("crowbar latch dropped");
	a_monitor_input_3_son_off: assert property (@(posedge clock) disable iff (sys_rst)
		st_reg.cfg[SLIO_CFG_MONITOR_INPUT_3_SEL] |-> ##1 !st_reg.power_on) else $error("supply on with monitor three");
	a_pen_level: assert property (@(posedge clock) disable iff (sys_rst)
		##1 converter_enable_out == ($past(st_reg.power_on) ^ $past(st_reg.cfg[SLIO_CFG_PEN_LOW])))
		else $error("converter enable level wrong");
	a_dcg_tolerance: assert property (@(posedge clock) disable iff (sys_rst)
		!dc_in_tolerance && !st_reg.cfg[SLIO_CFG_MONITOR_INPUT_4_SEL] |=> output_power_good_oe)
		else $error("output good not pulled low");
	a_on_delay: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(st_reg.gate_on) |-> $past(st_reg.dly_cnt) == SLIO_ON_DLY_TICKS) else $error("on delay short");
	a_alert_pull_low: assert property (@(posedge clock) disable iff (sys_rst)
		st_reg.cfg[SLIO_CFG_CB_ALERT] && cb_act |=> crowbar_drive_oe && !crowbar_drive_out)
		else $error("alert pin not pulled low");
	a_line_good_mode: assert property (@(posedge clock) disable iff (sys_rst)
		st_reg.cfg[SLIO_CFG_REF_LO +: 2] != SLIO_REF_ACOK |=> !line_power_good_oe)
		else $error("line good driven outside its pin mode");
	c_gate_on: cover property (@(posedge clock) disable iff (sys_rst) $rose(st_reg.gate_on));
	c_reverse_trip: cover property (@(posedge clock) disable iff (sys_rst) st_reg.gate_on ##1 !st_reg.gate_on);
	c_crowbar_latch: cover property (@(posedge clock) disable iff (sys_rst) $rose(st_reg.cb_latched));
endmodule

`default_nettype wire

// [dv/slio_stage_model.sv]
// power stage model: transistor voltage comparators seen by the block
// assumes gate polarity is told by the bench from its configuration copy
`timescale 1ns/1ps
`default_nettype none
module slio_stage_model (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic stage_up,
	input  wire logic rect_fail,
	input  wire logic gate_drive_out,
	input  wire logic gate_inv,
	output logic      near_zero_cmp,
	output logic      reverse_cmp
);
	logic conducting;
	// ==========================================================
	// comparators
	// a reverse voltage only builds up while the transistor conducts
	assign conducting = gate_inv ? gate_drive_out : ~gate_drive_out;
	// registered, like a slow amplifier settling
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			near_zero_cmp <= 1'b0;
			reverse_cmp   <= 1'b0;
		end else begin
			near_zero_cmp <= stage_up & ~rect_fail;
			reverse_cmp   <= rect_fail & conducting;
		end
	end
endmodule
`default_nettype wire

// [dv/tb_supply_logic_io_and_fault_pins.sv]
// testbench of the logic i/o and fault pin block, apb register access
// assumes an apb slave on the system clock and the stage model beside the gate pins
`timescale 1ns/1ps
`default_nettype none
module tb_supply_logic_io_and_fault_pins;
	import slio_pkg::*;
	logic clock, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, cfg;
	logic near_zero_cmp, reverse_cmp, line_sense_1, line_sense_2, supply_on_request, dc_in_tolerance;
	logic ov_fault, uv_fault, oc_fault, stage_up, rect_fail;
	logic monitor_input_1, monitor_input_2, monitor_input_3, monitor_input_4, monitor_input_5;
	logic son_out, son_oe, lg_out, lg_oe, gate_drive_out, gate_drive_oe, crowbar_drive_out, crowbar_drive_oe;
	logic converter_enable_out, output_power_good, output_power_good_oe, line_power_good, line_power_good_oe;
	logic ref_enable_out;
	logic [3:0] on_thr_code, off_thr_code;
	int num_errors, num_checks, cycles;
	// ==========================================================
	// design and far side
	slio_core slio_core_inst (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .near_zero_cmp(near_zero_cmp), .reverse_cmp(reverse_cmp),
		.line_sense_1(line_sense_1), .line_sense_2(line_sense_2), .supply_on_request(supply_on_request),
		.dc_in_tolerance(dc_in_tolerance), .ov_fault(ov_fault), .uv_fault(uv_fault), .oc_fault(oc_fault),
		.monitor_input_1(monitor_input_1), .monitor_input_2(monitor_input_2),
		.monitor_input_3(monitor_input_3), .monitor_input_4(monitor_input_4),
		.monitor_input_5(monitor_input_5), .supply_on_share_line_in(~son_oe),
		.supply_on_share_line_out(son_out), .supply_on_share_line_oe(son_oe),
		.line_good_share_line_in(~lg_oe), .line_good_share_line_out(lg_out),
		.line_good_share_line_oe(lg_oe), .gate_drive_out(gate_drive_out), .gate_drive_oe(gate_drive_oe),
		.crowbar_drive_out(crowbar_drive_out), .crowbar_drive_oe(crowbar_drive_oe),
		.converter_enable_out(converter_enable_out), .output_power_good(output_power_good),
		.output_power_good_oe(output_power_good_oe), .line_power_good(line_power_good),
		.line_power_good_oe(line_power_good_oe), .ref_enable_out(ref_enable_out),
		.on_thr_code(on_thr_code), .off_thr_code(off_thr_code));
	slio_stage_model slio_stage_model_inst (.clock(clock), .sys_rst(sys_rst), .stage_up(stage_up),
		.rect_fail(rect_fail), .gate_drive_out(gate_drive_out), .gate_inv(cfg[SLIO_CFG_GATE_INV]),
		.near_zero_cmp(near_zero_cmp), .reverse_cmp(reverse_cmp));
	// ==========================================================
	// clock and hang guard; whole run is a few hundred cycles
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			results();
		end
	end
	// ==========================================================
	// helpers
	task automatic results();
		if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one apb transfer, request held until pready is seen high
	task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= we;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		// no count limit here; pready high or the bench timeout ends this wait
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		chk("pslverr", 0, pslverr);
		// bus left idle between transfers
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wcfg(input logic [31:0] v);
		cfg = v;
		apb(1'b1, SLIO_PIN_CFG_OFF, v);
	endtask
	function automatic logic sig(input int w);
		case (w)
			0: return gate_drive_out;
			1: return converter_enable_out;
			2: return crowbar_drive_oe;
			3: return line_power_good_oe;
			4: return output_power_good_oe;
			5: return crowbar_drive_out;
			6: return line_power_good;
			default: return ref_enable_out;
		endcase
	endfunction
	// bounded wait for a pin level, then compare it
	task automatic poll(input int w, input logic e, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (sig(w) !== e && n < lim);
		chk($sformatf("pin%0d", w), {31'h0, e}, {31'h0, sig(w)});
		// return on an edge so the next stimulus lands on it
		@(posedge clock);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, cfg, cycles, num_errors, num_checks} = '0;
		{line_sense_1, line_sense_2, supply_on_request, dc_in_tolerance, ov_fault, uv_fault} = '0;
		{oc_fault, stage_up, rect_fail, monitor_input_1, monitor_input_2} = '0;
		{monitor_input_3, monitor_input_4, monitor_input_5} = '0;
		sys_rst = 1'b1;
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		#1;
		chk("gate_rst", 1, gate_drive_out);
		chk("ref_rst", 1, ref_enable_out);
		chk("gate_oe_rst", 0, gate_drive_oe);
		apb(1'b0, SLIO_PIN_CFG_OFF, 0);
		chk("cfg_rst", 0, rd);
		apb(1'b0, 8'h40, 0);
		chk("unmapped", 0, rd);
		apb(1'b1, SLIO_THR_CFG_OFF, 32'h53);
		apb(1'b0, SLIO_THR_CFG_OFF, 0);
		chk("thr_rd", 32'h53, rd);
		chk("on_thr", 3, on_thr_code);
		chk("off_thr", 5, off_thr_code);
		supply_on_request <= 1'b1;
		dc_in_tolerance <= 1'b1;
		poll(1, 1, 100);
		poll(4, 0, 100);
		// gate waits four ticks of near zero, one tick of slack allowed
		@(posedge clock) stage_up <= 1'b1;
		repeat (24) @(posedge clock);
		#1;
		chk("gate_early", 1, gate_drive_out);
		poll(0, 0, 40);
		apb(1'b0, SLIO_STATUS_OFF, 0);
		chk("stat_gate", 1, {31'h0, rd[0]});
		rect_fail <= 1'b1;
		poll(0, 1, 5);
		rect_fail <= 1'b0;
		poll(0, 0, 60);
		wcfg(32'h1 << SLIO_CFG_GATE_INV);
		poll(0, 1, 5);
		rect_fail <= 1'b1;
		poll(0, 0, 5);
		rect_fail <= 1'b0;
		poll(0, 1, 60);
		wcfg(cfg | (32'h1 << SLIO_CFG_PEN_LOW));
		poll(1, 0, 5);
		dc_in_tolerance <= 1'b0;
		poll(4, 1, 10);
		dc_in_tolerance <= 1'b1;
		// crowbar on the overvoltage flag, following then latching; idle n drain pulls low
		apb(1'b1, SLIO_FLAG_SEL_LO_OFF, 32'h1);
		ov_fault <= 1'b1;
		poll(2, 0, 8);
		ov_fault <= 1'b0;
		poll(2, 1, 8);
		wcfg(cfg | (32'h1 << SLIO_CFG_CB_LATCH));
		ov_fault <= 1'b1;
		poll(2, 0, 8);
		ov_fault <= 1'b0;
		repeat (8) @(posedge clock);
		#1;
		chk("cb_latched", 0, crowbar_drive_oe);
		apb(1'b1, SLIO_CTRL_OFF, 32'h8);
		poll(2, 1, 8);
		wcfg(cfg | (32'h1 << SLIO_CFG_CB_INV));
		poll(2, 0, 8);
		wcfg(cfg | (32'h1 << SLIO_CFG_CB_PCH));
		poll(5, 1, 8);
		poll(2, 1, 8);
		// processor written flag, crowbar then alert use
		wcfg(32'h1 << SLIO_CFG_GATE_INV | 32'h1 << SLIO_CFG_PEN_LOW);
		apb(1'b1, SLIO_FLAG_SEL_LO_OFF, 0);
		apb(1'b1, SLIO_FLAG_SEL_HI_OFF, 32'h30);
		apb(1'b1, SLIO_CTRL_OFF, 32'h1);
		poll(2, 0, 8);
		apb(1'b1, SLIO_CTRL_OFF, 0);
		poll(2, 1, 8);
		wcfg(cfg | (32'h1 << SLIO_CFG_CB_ALERT));
		apb(1'b1, SLIO_CTRL_OFF, 32'h1);
		poll(2, 1, 8);
		apb(1'b1, SLIO_CTRL_OFF, 0);
		poll(2, 0, 8);
		// line good shares the reference pin, so select that mode first
		wcfg(cfg | (32'(SLIO_REF_ACOK) << SLIO_CFG_REF_LO));
		poll(7, 0, 4);
		poll(3, 1, 8);
		line_sense_1 <= 1'b1;
		poll(3, 0, 8);
		line_sense_1 <= 1'b0;
		poll(3, 1, 8);
		wcfg(cfg | (32'h1 << SLIO_CFG_MONITOR_INPUT_1_SEL));
		poll(3, 0, 8);
		wcfg(cfg | (32'h1 << SLIO_CFG_AC_SRC2));
		poll(3, 1, 8);
		wcfg(cfg | (32'h1 << SLIO_CFG_MONITOR_INPUT_2_SEL));
		poll(3, 0, 8);
		wcfg(cfg | (32'h1 << SLIO_CFG_AC_INV));
		poll(3, 1, 8);
		wcfg(cfg | (32'h1 << SLIO_CFG_AC_PCH));
		poll(6, 1, 8);
		poll(1, 0, 200);
		// supply on taken from the bus once the pin path is broken
		wcfg(cfg | (32'h1 << SLIO_CFG_SON_BREAK));
		poll(1, 1, 100);
		apb(1'b1, SLIO_CTRL_OFF, 32'h2);
		poll(1, 0, 100);
		wcfg(cfg | (32'h1 << SLIO_CFG_MONITOR_INPUT_3_SEL));
		poll(1, 1, 100);
		// locked configuration ignores later writes
		wcfg(cfg | (32'h1 << SLIO_CFG_LOCK));
		apb(1'b1, SLIO_PIN_CFG_OFF, 0);
		apb(1'b0, SLIO_PIN_CFG_OFF, 0);
		chk("cfg_locked", cfg, rd);
		results();
	end
endmodule
`default_nettype wire
